// >>> rtl/mss_supervisor.v
// motor start and locked-rotor stall supervisor with an ahb-lite register slave
// assumes one 50 MHz clock, current samples as unsigned 1/16 x nominal, async speed switch
//
// Functional notes
// - start time checked by definite time or by inverse current-squared-time budget
// - inverse mode: lower current gives a longer allowed start time, in inverse proportion to current squared
// - allowed time from manual setting or hot/cold stall times given thermal state
// - accumulate current-squared-time during start, continue while within limit
// - trip when start exceeds allowed time without speed switch extension
// - with speed switch in use and high, start may pass allowed time
// - even with speed switch high, trip once safe stall time passes
// - stall monitoring uses the same time and current-squared-time settings
// - stall watch: definite time or i2t with speed switch, trip on excess
// - start detected only if current passes both limits within ten milliseconds
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mss_defines.vh"

module mss_supervisor (
    // bus clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // motor side
    input  wire [11:0] motor_current,
    input  wire        speed_switch,
    input  wire        thermal_hot,
    output reg         trip,
    output reg         irq
);

    // one-hot supervision states
    localparam [4:0] S_IDLE  = 5'b00001;
    localparam [4:0] S_START = 5'b00010;
    localparam [4:0] S_RUN   = 5'b00100;
    localparam [4:0] S_STALL = 5'b01000;
    localparam [4:0] S_TRIP  = 5'b10000;

    // registers
    reg [`MSS_CTRL_W-1:0] ctrl_q;
    reg [15:0]            tstart_q;
    reg [15:0]            tstall_q;
    reg [15:0]            tcold_q;
    reg [15:0]            thot_q;
    reg [11:0]            inom_q;
    reg [11:0]            noload_q;
    reg [11:0]            detect_q;
    reg [11:0]            stalli_q;
    reg [`MSS_IRQ_W-1:0]  irq_stat_q;
    reg [`MSS_IRQ_W-1:0]  irq_en_q;
    // bus data phase
    reg                   wr_pend_q;
    reg [7:0]             wr_addr_q;
    // synchronisers
    reg                   spd_s1_q;
    reg                   spd_s2_q;
    reg                   hot_s1_q;
    reg                   hot_s2_q;
    // supervision state
    reg [4:0]             state_q;
    reg [15:0]            tick_q;
    reg [15:0]            ms_q;
    reg [3:0]             det_q;
    reg                   det_arm_q;
    reg [47:0]            acc_q;
    reg [`MSS_IRQ_W-1:0]  ev;

    wire       en      = ctrl_q[`MSS_CTRL_EN];
    wire       i2t     = ctrl_q[`MSS_CTRL_I2T];
    wire       spd_use = ctrl_q[`MSS_CTRL_SPDSW];
    wire       tick    = (tick_q == `MSS_TICK_LAST);
    wire       spd_ok  = spd_use & spd_s2_q;
    wire       above_nl  = motor_current > noload_q;
    wire       above_det = motor_current > detect_q;
    wire       above_st  = motor_current > stalli_q;
    // hot/cold safe stall time follows the thermal state when automatic
    wire [15:0] t_allow = ctrl_q[`MSS_CTRL_AUTO] ? (hot_s2_q ? thot_q : tcold_q) : tstart_q;
    wire [15:0] t_safe  = hot_s2_q ? thot_q : tcold_q;
    // budget = inom_start^2 * t_allow; at lower current i^2 accumulates slower, so time stretches
    wire [23:0] isq      = motor_current * motor_current;
    wire [23:0] inom_sq  = inom_q * inom_q;
    wire [47:0] budget   = inom_sq * {8'h00, t_allow};
    wire        over_def = ms_q >= t_allow;
    wire        over_i2t = acc_q > budget;
    wire        over     = i2t ? over_i2t : over_def;
    // speed switch extends up to the safe stall time only
    wire        over_plain = over & ~spd_ok;
    wire        over_safe  = spd_ok & (ms_q >= t_safe);
    // with the speed switch high the safe stall time still bounds the start, so a stuck speed switch cannot hold off a trip
    wire        trip_now   = over_plain | over_safe;
    wire [47:0] acc_step   = {24'h0, isq};

    wire       acc_ok  = hsel & hready & htrans[1];

    // one-hot state decode for the status word
    wire       in_idle  = state_q == S_IDLE;
    wire       in_start = state_q == S_START;
    wire       in_run   = state_q == S_RUN;
    wire       in_stall = state_q == S_STALL;
    wire       in_trip  = state_q == S_TRIP;
    wire [31:0] status = {27'h0, in_trip, in_stall, in_run, in_start, in_idle};

    // ahb-lite: zero wait states, write lands in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
        end else begin
            wr_pend_q <= acc_ok & hwrite;
            if (acc_ok)
                wr_addr_q <= haddr;
            hrdata <= 32'h0;
            if (acc_ok & ~hwrite) begin
                case ({haddr[7:2], 2'b00})
                    `MSS_CTRL_OFF:     hrdata <= {26'h0, ctrl_q};
                    `MSS_TSTART_OFF:   hrdata <= {16'h0, tstart_q};
                    `MSS_TSTALL_OFF:   hrdata <= {16'h0, tstall_q};
                    `MSS_TCOLD_OFF:    hrdata <= {16'h0, tcold_q};
                    `MSS_THOT_OFF:     hrdata <= {16'h0, thot_q};
                    `MSS_INOM_OFF:     hrdata <= {20'h0, inom_q};
                    // stall limit is fixed and fits a byte, so only its low byte reads back
                    `MSS_LIMITS_OFF:   hrdata <= {stalli_q[7:0], detect_q, noload_q};
                    `MSS_STATUS_OFF:   hrdata <= {status[31:6], spd_s2_q, status[4:0]};
                    `MSS_IRQ_STAT_OFF: hrdata <= {29'h0, irq_stat_q};
                    `MSS_IRQ_EN_OFF:   hrdata <= {29'h0, irq_en_q};
                    `MSS_ACCUM_OFF:    hrdata <= acc_q[47:16];
                    default:           hrdata <= 32'h0;
                endcase
            end
        end
    end

    // configuration writes land one edge after the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= `MSS_CTRL_RST;
            tstart_q <= `MSS_TSTART_RST;
            tstall_q <= `MSS_TSTALL_RST;
            tcold_q  <= `MSS_TCOLD_RST;
            thot_q   <= `MSS_THOT_RST;
            inom_q   <= `MSS_INOM_RST;
            noload_q <= `MSS_NOLOAD_RST;
            detect_q <= `MSS_DETECT_RST;
            stalli_q <= `MSS_STALLI_RST;
            irq_en_q <= {`MSS_IRQ_W{1'b0}};
        end else begin
            ctrl_q[`MSS_CTRL_RESET] <= 1'b0;
            if (wr_pend_q) begin
                case ({wr_addr_q[7:2], 2'b00})
                    `MSS_CTRL_OFF:   ctrl_q   <= hwdata[`MSS_CTRL_W-1:0];
                    `MSS_TSTART_OFF: tstart_q <= hwdata[15:0];
                    `MSS_TSTALL_OFF: tstall_q <= hwdata[15:0];
                    `MSS_TCOLD_OFF:  tcold_q  <= hwdata[15:0];
                    `MSS_THOT_OFF:   thot_q   <= hwdata[15:0];
                    `MSS_INOM_OFF:   inom_q   <= hwdata[11:0];
                    `MSS_LIMITS_OFF: begin
                        noload_q <= hwdata[11:0];
                        detect_q <= hwdata[23:12];
                    end
                    `MSS_IRQ_EN_OFF: irq_en_q <= hwdata[`MSS_IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // interrupt status: a set in the same cycle as its clear wins
    wire                  clr_wr     = wr_pend_q && ({wr_addr_q[7:2], 2'b00} == `MSS_IRQ_CLR_OFF);
    wire [`MSS_IRQ_W-1:0] clr_mask   = clr_wr ? hwdata[`MSS_IRQ_W-1:0] : {`MSS_IRQ_W{1'b0}};
    wire [`MSS_IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~clr_mask) | ev;

    // irq follows the next status so a clear drops it on the same edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= {`MSS_IRQ_W{1'b0}};
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq        <= |(irq_stat_d & irq_en_q);
        end
    end

    // speed switch and thermal state come from outside the clock domain
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spd_s1_q <= 1'b0;
            spd_s2_q <= 1'b0;
            hot_s1_q <= 1'b0;
            hot_s2_q <= 1'b0;
        end else begin
            spd_s1_q <= speed_switch;
            spd_s2_q <= spd_s1_q;
            hot_s1_q <= thermal_hot;
            hot_s2_q <= hot_s1_q;
        end
    end

    // events: start detected, trip, start finished below the detect limit
    always @* begin
        ev = {`MSS_IRQ_W{1'b0}};
        if (state_q == S_IDLE && det_arm_q && above_nl && above_det && en)
            ev[`MSS_IRQ_START] = 1'b1;
        if ((state_q == S_START || state_q == S_STALL) && trip_now)
            ev[`MSS_IRQ_TRIP] = 1'b1;
        if (state_q == S_START && !trip_now && !above_det)
            ev[`MSS_IRQ_DONE] = 1'b1;
    end

    // supervision: millisecond tick, start detect window, timer and i2t accumulator
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= S_IDLE;
            tick_q    <= 16'h0;
            ms_q      <= 16'h0;
            det_q     <= 4'h0;
            det_arm_q <= 1'b0;
            acc_q     <= 48'h0;
            trip      <= 1'b0;
        end else begin
            // tick runs free except at a start or stall entry, where it restarts
            tick_q <= tick ? 16'h0 : tick_q + 16'h1;
            // disable or a reset pulse drops a trip and restarts detection
            if (!en || ctrl_q[`MSS_CTRL_RESET]) begin
                state_q   <= S_IDLE;
                ms_q      <= 16'h0;
                acc_q     <= 48'h0;
                det_q     <= 4'h0;
                det_arm_q <= 1'b0;
                trip      <= 1'b0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        ms_q  <= 16'h0;
                        acc_q <= 48'h0;
                        // rise from below no-load must clear both limits within the window
                        if (!above_nl) begin
                            det_q     <= 4'h0;
                            det_arm_q <= 1'b1;
                        end else if (tick && det_arm_q) begin
                            if (det_q == `MSS_DET_LAST) begin
                                det_arm_q <= 1'b0;
                            end
                            det_q <= det_q + 4'h1;
                        end
                        if (ev[`MSS_IRQ_START]) begin
                            // a whole first millisecond, so a start is never cut short
                            state_q <= S_START;
                            tick_q  <= 16'h0;
                        end
                    end
                    S_START, S_STALL: begin
                        if (tick) begin
                            ms_q  <= ms_q + 16'h1;
                            // one current-squared sample per millisecond
                            acc_q <= acc_q + acc_step;
                        end
                        if (trip_now) begin
                            trip    <= 1'b1;
                            state_q <= S_TRIP;
                        end else if (state_q == S_START ? !above_det : !above_st) begin
                            ms_q    <= 16'h0;
                            acc_q   <= 48'h0;
                            state_q <= S_RUN;
                        end
                    end
                    S_RUN: begin
                        ms_q  <= 16'h0;
                        acc_q <= 48'h0;
                        if (!above_nl) begin
                            state_q   <= S_IDLE;
                            det_arm_q <= 1'b1;
                            det_q     <= 4'h0;
                        end else if (ctrl_q[`MSS_CTRL_STALL] && above_st) begin
                            state_q <= S_STALL;
                            tick_q  <= 16'h0;
                        end
                    end
                    // trip holds until software disables or pulses reset
                    S_TRIP: trip <= 1'b1;
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

endmodule

// >>> rtl/mss_defines.vh
// register map, field positions, reset values and timing counts of the start/stall supervisor
// assumes the includer runs at 50 MHz on hclk
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH

// register byte offsets
`define MSS_CTRL_OFF      8'h00
`define MSS_TSTART_OFF    8'h04
`define MSS_TSTALL_OFF    8'h08
`define MSS_TCOLD_OFF     8'h0c
`define MSS_THOT_OFF      8'h10
`define MSS_INOM_OFF      8'h14
`define MSS_LIMITS_OFF    8'h18
`define MSS_STATUS_OFF    8'h1c
`define MSS_IRQ_STAT_OFF  8'h20
`define MSS_IRQ_EN_OFF    8'h24
`define MSS_IRQ_CLR_OFF   8'h28
`define MSS_ACCUM_OFF     8'h2c

// control fields
`define MSS_CTRL_EN       0
`define MSS_CTRL_I2T      1
`define MSS_CTRL_AUTO     2
`define MSS_CTRL_SPDSW    3
`define MSS_CTRL_STALL    4
`define MSS_CTRL_RESET    5
`define MSS_CTRL_W        6
`define MSS_CTRL_RST      6'h00

// status fields
`define MSS_ST_IDLE       0
`define MSS_ST_START      1
`define MSS_ST_RUN        2
`define MSS_ST_STALL      3
`define MSS_ST_TRIP       4

// interrupt bits
`define MSS_IRQ_START     0
`define MSS_IRQ_TRIP      1
`define MSS_IRQ_DONE      2
`define MSS_IRQ_W         3

// reset values (times in milliseconds, currents in 1/16 x nominal)
`define MSS_TSTART_RST    16'd10000
`define MSS_TSTALL_RST    16'd20000
`define MSS_TCOLD_RST     16'd20000
`define MSS_THOT_RST      16'd15000
`define MSS_INOM_RST      12'd96
`define MSS_NOLOAD_RST    12'd2
`define MSS_DETECT_RST    12'd24
`define MSS_STALLI_RST    12'd56

// timing: one millisecond tick, start detect window
`define MSS_CLK_HZ        50000000
`define MSS_TICK_NS       1000000
`define MSS_TICK_CYC      (`MSS_CLK_HZ / 1000)
`define MSS_DET_MS        10
`define MSS_TICK_LAST     16'd49999
`define MSS_DET_LAST      4'd9

`endif

// >>> tb/mss_chk.sv
// checker: bus answer and trip behaviour seen at the supervisor ports
// assumes default current limits and binding from the testbench top
`timescale 1ns/1ps
module mss_chk (
    // clock and reset
    input wire        hclk,
    input wire        hresetn,
    // bus
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // motor
    input wire [11:0] motor_current,
    input wire        trip,
    input wire        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd = hsel && hready && htrans[1] && !hwrite;
    wire wr = hsel && hready && htrans[1] && hwrite;
    reg  wr_q;
    reg  wr_q2;
    // a control write clears the trip two edges after its address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q  <= 1'b0;
            wr_q2 <= 1'b0;
        end else begin
            wr_q  <= wr;
            wr_q2 <= wr_q;
        end
    end
    a_bus_ready: assert property (hreadyout) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_unmapped_zero: assert property (rd && haddr == 8'h30 |=> hrdata == 32'h0) else $error("unmapped read");
    a_trip_sticky: assert property (trip && !wr && !wr_q && !wr_q2 |=> trip) else $error("trip dropped");
    a_trip_cause: assert property ($rose(trip) |-> $past(motor_current) > 12'd2) else $error("trip at rest");
    a_quiet_no_trip: assert property ((!trip && motor_current <= 12'd24)[*3] |=> !trip) else $error("late trip");
    a_status_trip: assert property (rd && haddr == 8'h1c && trip && !wr_q |=> hrdata[4]) else $error("status");
    a_reset_clean: assert property ($rose(hresetn) |-> !trip && !irq) else $error("dirty reset");
    c_trip: cover property ($rose(trip));
    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (rd && haddr == 8'h30);
endmodule

// >>> tb/mss_motor_model.sv
// motor side model: current source and speed switch seen by the supervisor
// assumes the bench sets level and spin just after a clock edge
`timescale 1ns/1ps
module mss_motor_model (
    // control from the bench
    input  wire        hclk,
    input  wire [11:0] level,
    input  wire        spin,
    // to the supervisor
    output reg  [11:0] motor_current = 12'h000,
    output reg         speed_switch = 1'b0
);
    // a step lands in one clock, so every rise is fast enough to count as a start
    always @(posedge hclk) begin
        motor_current <= level;
        speed_switch <= spin && (level != 12'h000);
    end
endmodule

// >>> tb/testbench.sv
// testbench: drives the supervisor over ahb-lite and through the motor model
// assumes default limits and the fixed 1 ms tick of the design
`timescale 1ns/1ps
`include "mss_defines.vh"
module testbench;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [7:0]  haddr = 8'h00;
    reg  [1:0]  htrans = 2'b00;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg  [11:0] level = 12'h000;
    reg         spin = 1'b0;
    reg         thermal_hot = 1'b0;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire        hresp;
    wire [11:0] motor_current;
    wire        speed_switch;
    wire        trip;
    wire        irq;
    integer     num_errors = 0;
    integer     checks = 0;
    integer     n;
    reg  [31:0] rd;
    mss_supervisor i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .motor_current(motor_current), .speed_switch(speed_switch),
        .thermal_hot(thermal_hot), .trip(trip), .irq(irq));
    mss_motor_model i_motor (.hclk(hclk), .level(level), .spin(spin), .motor_current(motor_current),
        .speed_switch(speed_switch));
    initial forever #10 hclk = ~hclk;
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            if (num_errors == 0 && checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // waits for trip (sel 1) or irq (sel 0), counting cycles
    task wait_for(input sel, input integer lim);
        begin
            n = 0;
            while ((sel ? trip : irq) !== 1'b1) begin
                @(posedge hclk);
                n = n + 1;
                if (n > lim) begin
                    check(32'h0, 32'h1);
                    wrap_up;
                end
            end
        end
    endtask
    task wait_rdy;
        begin
            @(posedge hclk);
            n = 0;
            while (hreadyout !== 1'b1) begin
                @(posedge hclk);
                n = n + 1;
                if (n > 50) begin
                    check(32'h0, 32'h1);
                    wrap_up;
                end
            end
        end
    endtask
    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            htrans <= 2'b10;
            hwrite <= w;
            haddr <= a;
            wait_rdy;
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= d;
            wait_rdy;
            rd = hrdata;
        end
    endtask
    task t_reset;
        begin
            check(32'(trip), 32'h0);
            check(32'(irq), 32'h0);
            xfer(1'b0, `MSS_STATUS_OFF, 32'h0);
            check(rd, 32'h1);
            xfer(1'b0, `MSS_ACCUM_OFF, 32'h0);
            check(rd, 32'h0);
        end
    endtask
    task t_regs;
        begin
            xfer(1'b1, `MSS_TSTART_OFF, 32'd1);
            xfer(1'b0, `MSS_TSTART_OFF, 32'h0);
            check(rd, 32'd1);
            xfer(1'b1, 8'h30, 32'h5a);
            xfer(1'b0, 8'h30, 32'h0);
            check(rd, 32'h0);
        end
    endtask
    // short start that ends below the detect limit: no trip, done event
    task t_start_run;
        begin
            xfer(1'b1, `MSS_IRQ_EN_OFF, 32'h7);
            xfer(1'b1, `MSS_CTRL_OFF, 32'h1);
            level <= 12'd80;
            wait_for(1'b0, 40);
            xfer(1'b0, `MSS_STATUS_OFF, 32'h0);
            check(32'(rd[`MSS_ST_START]), 32'h1);
            level <= 12'd12;
            repeat (4) @(posedge hclk);
            xfer(1'b0, `MSS_STATUS_OFF, 32'h0);
            check(32'(rd[`MSS_ST_RUN]), 32'h1);
            xfer(1'b0, `MSS_IRQ_STAT_OFF, 32'h0);
            check(rd, 32'h5);
            check(32'(trip), 32'h0);
            level <= 12'h000;
            xfer(1'b1, `MSS_IRQ_CLR_OFF, 32'h7);
            repeat (3) @(posedge hclk);
            check(32'(irq), 32'h0);
        end
    endtask
    // idle the motor and rewrite control with a reset pulse, which drops any trip
    task rearm(input [31:0] c);
        begin
            level <= 12'h000;
            spin <= 1'b0;
            xfer(1'b1, `MSS_CTRL_OFF, c | 32'h20);
            repeat (3) @(posedge hclk);
        end
    endtask
    // current above no-load first so the speed switch settles before the start
    task run_up(input s);
        begin
            spin <= s;
            level <= 12'd12;
            repeat (5) @(posedge hclk);
            level <= 12'd80;
            repeat (12) @(posedge hclk);
        end
    endtask
    // zero allowed times give answers within a few cycles instead of milliseconds
    task t_fast;
        begin
            xfer(1'b1, `MSS_TSTART_OFF, 32'd0);
            rearm(32'h3);
            run_up(1'b0);
            check(32'(trip), 32'h0);
            rearm(32'h1);
            run_up(1'b0);
            check(32'(trip), 32'h1);
            rearm(32'h9);
            run_up(1'b1);
            check(32'(trip), 32'h0);
            spin <= 1'b0;
            repeat (8) @(posedge hclk);
            check(32'(trip), 32'h1);
            xfer(1'b1, `MSS_TCOLD_OFF, 32'd0);
            rearm(32'h9);
            run_up(1'b1);
            check(32'(trip), 32'h1);
            thermal_hot <= 1'b1;
            rearm(32'h5);
            run_up(1'b0);
            check(32'(trip), 32'h0);
            thermal_hot <= 1'b0;
            repeat (8) @(posedge hclk);
            check(32'(trip), 32'h1);
            xfer(1'b1, `MSS_TCOLD_OFF, 32'd20000);
            rearm(32'h19);
            run_up(1'b1);
            level <= 12'd12;
            repeat (4) @(posedge hclk);
            level <= 12'd80;
            repeat (4) @(posedge hclk);
            xfer(1'b0, `MSS_STATUS_OFF, 32'h0);
            check(32'(rd[`MSS_ST_STALL]), 32'h1);
            check(32'(rd[5]), 32'h1);
            check(32'(trip), 32'h0);
            spin <= 1'b0;
            repeat (8) @(posedge hclk);
            check(32'(trip), 32'h1);
            xfer(1'b1, `MSS_TSTART_OFF, 32'd1);
            rearm(32'h1);
            xfer(1'b1, `MSS_IRQ_CLR_OFF, 32'h7);
        end
    endtask
    // definite-time start held above the detect limit past the 1 ms allowance
    task t_trip;
        begin
            level <= 12'd80;
            wait_for(1'b1, 60000);
            check(32'(n > 50000), 32'h1);
            xfer(1'b0, `MSS_IRQ_STAT_OFF, 32'h0);
            check(32'(rd[`MSS_IRQ_TRIP]), 32'h1);
            check(32'(irq), 32'h1);
            xfer(1'b1, `MSS_IRQ_CLR_OFF, 32'h7);
            level <= 12'h000;
            xfer(1'b1, `MSS_CTRL_OFF, 32'h21);
            repeat (3) @(posedge hclk);
            check(32'(trip), 32'h0);
            check(32'(irq), 32'h0);
        end
    endtask
    initial begin
        repeat (90000) @(posedge hclk);
        check(32'h0, 32'h1);
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_regs;
        t_start_run;
        t_fast;
        t_trip;
        wrap_up;
    end
endmodule
bind mss_supervisor mss_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .motor_current(motor_current), .trip(trip), .irq(irq));
